// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tccr_pkg::*;
  logic          clk, rst, trap_valid, trap_use_imm, trap_word, cr_valid;
  logic [4:0]    mask, cr_dst, cr_src;
  logic [63:0]   op_a, op_b;
  logic [15:0]   imm;
  logic [31:0]   cr_in, cr_out;
  logic          trap_req, trap_done, cr_wr;
  tccr_crop_type cr_op;
  int            miscompares, compares, taken, retired, issued, trapped;
  logic [4:0]    masks [12] = '{TO_LT, TO_NE, TO_LGE, TO_ALWAYS, 5'h14, 5'h04,
                                5'h0c, 5'h08, 5'h02, 5'h06, 5'h01, COND_NONE};

  tccr_unit DUT (.clk(clk), .rst(rst), .trap_valid(trap_valid),
    .trap_use_imm(trap_use_imm), .trap_word(trap_word), .trap_condition_mask(mask),
    .first_operand_reg(op_a), .second_operand_reg(op_b), .signed_immediate_field(imm),
    .trap_req(trap_req), .trap_done(trap_done), .cr_valid(cr_valid), .cr_op(cr_op),
    .cr_dst(cr_dst), .cr_src(cr_src), .cr_in(cr_in), .cr_wr(cr_wr), .cr_out(cr_out));
  tccr_pipe_model partner (.clk(clk), .rst(rst), .trap_req(trap_req),
    .trap_done(trap_done), .taken(taken), .retired(retired));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Valid stays up between calls so issues run back to back
  task do_trap(input logic w, input logic s, input logic [4:0] m,
               input logic [63:0] a, input logic [63:0] b, input logic [15:0] i);
    logic [63:0] x, y;
    logic        e;
    y = s ? {{48{i[15]}}, i} : b;
    x = a;
    if (w) begin
      x = {{32{a[31]}}, a[31:0]};
      y = {{32{y[31]}}, y[31:0]};
    end
    e = |(m & {$signed(x) < $signed(y), $signed(x) > $signed(y), x == y, x < y, x > y});
    {trap_valid, trap_word, trap_use_imm, mask, op_a, op_b, imm} = {1'b1, w, s, m, a, b, i};
    issued++;
    if (e) trapped++;
    @(negedge clk);
    check(trap_req, e);
    check(trap_done, !e);
  endtask

  task do_cr(input tccr_crop_type op, input logic [4:0] d, input logic [4:0] s,
             input logic [31:0] v);
    logic [31:0] e;
    e = v;
    case (op)
      TCCR_CR_SET:  e[d] = 1'b1;
      TCCR_CR_CLR:  e[d] = 1'b0;
      TCCR_CR_MOVE: e[d] = v[s];
      default:      e[d] = ~v[s];
    endcase
    cr_op = op;
    {cr_valid, cr_dst, cr_src, cr_in} = {1'b1, d, s, v};
    @(negedge clk);
    check(cr_wr, 1'b1);
    check(cr_out, e);
  endtask

  task scen_reset;
    {rst, trap_valid, trap_use_imm, trap_word, cr_valid, mask} = {1'b1, 9'h000};
    {op_a, op_b, imm, cr_in, cr_dst, cr_src} = '0;
    cr_op = TCCR_CR_SET;
    repeat (4) @(negedge clk);
    check({trap_req, trap_done, cr_wr, cr_out}, 64'h0);
    rst = 1'b0;
    @(negedge clk);
    check({trap_req, trap_done, cr_wr, cr_out}, 64'h0);
  endtask

  // High halves differ from the sign so word forms must ignore them
  task scen_trap_codes;
    for (int k = 0; k < 12; k++) begin
      do_trap(1'b0, 1'b0, masks[k], 64'hffff_ffff_ffff_ffff, 64'h1, 16'h0);
      do_trap(1'b0, 1'b0, masks[k], 64'h5, 64'h5, 16'h0);
      do_trap(1'b1, 1'b0, masks[k], 64'h1_0000_0001, 64'h2_0000_0001, 16'h0);
      do_trap(1'b1, 1'b0, masks[k], 64'h8000_0000, 64'h1, 16'h0);
      do_trap(1'b1, 1'b1, masks[k], 64'h800, 64'h0, 16'h07ff);
      do_trap(1'b0, 1'b1, masks[k], 64'hffff_ffff_ffff_ffff, 64'h0, 16'hffff);
      do_trap(1'b0, 1'b0, masks[k], 64'h1_0000_0001, 64'h2_0000_0001, 16'h0);
      do_trap(1'b1, 1'b0, masks[k], 64'hdead_beef_0000_0005, 64'hffff_fffb, 16'h0);
    end
    trap_valid = 1'b0;
  endtask

  task scen_cr_ops;
    for (int k = 0; k < 4; k++) begin
      do_cr(tccr_crop_type'(k), 5'd25, 5'd18, 32'h0004_0000);
      do_cr(tccr_crop_type'(k), 5'd0, 5'd31, 32'h7fff_ffff);
    end
    cr_valid = 1'b0;
  endtask

  task scen_idle;
    @(negedge clk);
    check({trap_req, trap_done, cr_wr}, 64'h0);
    check(cr_out, 32'h7fff_ffff);
    check(taken + retired, issued);
    check(taken, trapped);
    check(retired, issued - trapped);
  endtask

  // Reset in mid-run clears results and tallies, then work resumes
  task scen_mid_reset;
    rst = 1'b1;
    @(negedge clk);
    check({trap_req, trap_done, cr_wr, cr_out}, 64'h0);
    issued  = 0;
    trapped = 0;
    rst = 1'b0;
    @(negedge clk);
    check({trap_req, trap_done, cr_wr, cr_out}, 64'h0);
    check(taken + retired, 64'h0);
    do_trap(1'b1, 1'b1, TO_ALWAYS, 64'h0, 64'h0, 16'h0);
    trap_valid = 1'b0;
    do_cr(TCCR_CR_NOT, 5'd7, 5'd1, 32'h0000_0004);
    cr_valid = 1'b0;
    @(negedge clk);
    check(taken, trapped);
    check(retired, issued - trapped);
  endtask

  initial begin
    scen_reset;
    scen_trap_codes;
    scen_cr_ops;
    scen_idle;
    scen_mid_reset;
    give_verdict;
  end
endmodule
`default_nettype wire

// File: tccr_compare.sv
`timescale 1ns/1ps
`default_nettype none
module tccr_compare
  import tccr_pkg::*;
#(
  parameter int W = XLEN
) (
  // Operands
  input  wire logic [W-1:0]      op_a,
  input  wire logic [W-1:0]      op_b,
  input  wire logic              word_mode,
  // Five condition bits
  output logic      [COND_W-1:0] cond
);
  logic [W-1:0] a_x;
  logic [W-1:0] b_x;
  logic         slt;
  logic         ult;
  logic         eq;

  // Word forms compare low half; sign-extend so signed order holds
  always_comb begin
    if (word_mode) begin
      a_x = {{(W-WORD_W){op_a[WORD_W-1]}}, op_a[WORD_W-1:0]};
      b_x = {{(W-WORD_W){op_b[WORD_W-1]}}, op_b[WORD_W-1:0]};
    end else begin
      a_x = op_a;
      b_x = op_b;
    end
  end

  always_comb begin
    eq  = (a_x == b_x);
    slt = ($signed(a_x) < $signed(b_x));
    // Equal sign extension keeps unsigned order of low halves
    ult = (a_x < b_x);
    cond          = COND_NONE;
    cond[MSK_SLT] = slt;
    cond[MSK_SGT] = !slt && !eq;
    cond[MSK_EQ]  = eq;
    cond[MSK_ULT] = ult;
    cond[MSK_UGT] = !ult && !eq;
  end
endmodule
`default_nettype wire

// File: tccr_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module tccr_pipe_model (
  // Pipeline side
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic trap_req,
  input  wire logic trap_done,
  // Tallies
  output int        taken,
  output int        retired
);
  // A trapping instruction must never also retire
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      taken   <= 0;
      retired <= 0;
    end else begin
      taken   <= taken + int'(trap_req);
      retired <= retired + int'(trap_done);
    end
  end
endmodule
`default_nettype wire

// File: tccr_pkg.sv
package tccr_pkg;
  localparam int XLEN         = 64;
  localparam int WORD_W       = 32;
  localparam int IMM_W        = 16;
  localparam int COND_W       = 5;
  localparam int CR_W         = 32;
  localparam int CR_IDX_W     = 5;
  // Mask bit positions, bit 4 is the MSB of the five-bit field
  localparam int MSK_SLT      = 4;
  localparam int MSK_SGT      = 3;
  localparam int MSK_EQ       = 2;
  localparam int MSK_ULT      = 1;
  localparam int MSK_UGT      = 0;
  localparam logic [4:0] TO_LT    = 5'h10;
  localparam logic [4:0] TO_NE    = 5'h18;
  localparam logic [4:0] TO_LGE   = 5'h05;
  localparam logic [4:0] TO_ALWAYS = 5'h1f;
  localparam logic [4:0] COND_NONE = 5'h00;

  typedef enum logic [1:0] {
    TCCR_CR_SET,
    TCCR_CR_CLR,
    TCCR_CR_MOVE,
    TCCR_CR_NOT
  } tccr_crop_type;
endpackage

// File: tccr_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tccr_unit
  import tccr_pkg::*;
#(
  parameter int W = XLEN
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Trap issue
  input  wire logic                trap_valid,
  input  wire logic                trap_use_imm,
  input  wire logic                trap_word,
  input  wire logic [COND_W-1:0]   trap_condition_mask,
  input  wire logic [W-1:0]        first_operand_reg,
  input  wire logic [W-1:0]        second_operand_reg,
  input  wire logic [IMM_W-1:0]    signed_immediate_field,
  // Trap result
  output logic                     trap_req,
  output logic                     trap_done,
  // CR bit op issue
  input  wire logic                cr_valid,
  input  wire tccr_crop_type       cr_op,
  input  wire logic [CR_IDX_W-1:0] cr_dst,
  input  wire logic [CR_IDX_W-1:0] cr_src,
  input  wire logic [CR_W-1:0]     cr_in,
  // CR result
  output logic                     cr_wr,
  output logic [CR_W-1:0]          cr_out
);
  logic [W-1:0]      b_sel;
  logic [COND_W-1:0] cond;
  logic [COND_W-1:0] hit;
  logic              trap_req_d;
  logic              trap_req_q;
  logic              trap_done_d;
  logic              trap_done_q;
  logic              cr_wr_d;
  logic              cr_wr_q;
  logic [CR_W-1:0]   cr_out_d;
  logic [CR_W-1:0]   cr_out_q;
  logic              src_bit;
  logic              new_bit;

  // Operand B: sign-extended immediate or register
  always_comb begin
    if (trap_use_imm) begin
      b_sel = {{(W-IMM_W){signed_immediate_field[IMM_W-1]}}, signed_immediate_field};
    end else begin
      b_sel = second_operand_reg;
    end
  end

  tccr_compare #(
    .W (W)
  ) u_cmp (
    .op_a      (first_operand_reg),
    .op_b      (b_sel),
    .word_mode (trap_word),
    .cond      (cond)
  );

  always_comb begin
    hit         = cond & trap_condition_mask;
    trap_req_d  = trap_valid && (hit != COND_NONE);
    // Completion only when no trap, keeps the exception precise
    trap_done_d = trap_valid && (hit == COND_NONE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trap_req_q  <= 1'b0;
      trap_done_q <= 1'b0;
    end else begin
      trap_req_q  <= trap_req_d;
      trap_done_q <= trap_done_d;
    end
  end

  assign trap_req  = trap_req_q;
  assign trap_done = trap_done_q;

  // Each operation is the logical op with both sources equal
  always_comb begin
    src_bit  = cr_in[cr_src];
    new_bit  = 1'b0;
    unique case (cr_op)
      TCCR_CR_SET:  new_bit = ~(cr_in[cr_dst] ^ cr_in[cr_dst]);
      TCCR_CR_CLR:  new_bit = cr_in[cr_dst] ^ cr_in[cr_dst];
      TCCR_CR_MOVE: new_bit = src_bit | src_bit;
      TCCR_CR_NOT:  new_bit = ~(src_bit | src_bit);
    endcase
    cr_out_d         = cr_out_q;
    cr_wr_d          = cr_valid;
    if (cr_valid) begin
      cr_out_d         = cr_in;
      cr_out_d[cr_dst] = new_bit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cr_wr_q  <= 1'b0;
      cr_out_q <= '0;
    end else begin
      cr_wr_q  <= cr_wr_d;
      cr_out_q <= cr_out_d;
    end
  end

  assign cr_wr  = cr_wr_q;
  assign cr_out = cr_out_q;

  a_trap_nonzero: assert property (@(posedge clk) disable iff (rst)
    trap_valid |=> trap_req == ($past(hit) != COND_NONE))
    else $error("trap request does not match masked conditions");

  a_trap_always: assert property (@(posedge clk) disable iff (rst)
    trap_valid && trap_condition_mask == TO_ALWAYS |=> trap_req)
    else $error("unconditional trap not raised");

  a_trap_lt: assert property (@(posedge clk) disable iff (rst)
    trap_valid && trap_condition_mask == TO_LT |=> trap_req == $past(cond[MSK_SLT]))
    else $error("less-than trap wrong");

  a_trap_ne: assert property (@(posedge clk) disable iff (rst)
    trap_valid && trap_condition_mask == TO_NE && first_operand_reg == b_sel
    && !trap_word |=> !trap_req)
    else $error("not-equal trap raised on equal operands");

  a_trap_lge: assert property (@(posedge clk) disable iff (rst)
    trap_valid && trap_condition_mask == TO_LGE |=> trap_req == !$past(cond[MSK_ULT]))
    else $error("unsigned greater-or-equal trap wrong");

  a_trap_excl: assert property (@(posedge clk) disable iff (rst)
    !(trap_req && trap_done))
    else $error("trapping instruction also completed");

  a_word_low: assert property (@(posedge clk) disable iff (rst)
    trap_valid && trap_word && !trap_use_imm && trap_condition_mask == 5'h04
    && first_operand_reg[WORD_W-1:0] == second_operand_reg[WORD_W-1:0] |=> trap_req)
    else $error("word compare looked at high bits");

  a_imm_sel: assert property (@(posedge clk) disable iff (rst)
    trap_use_imm |-> b_sel[W-1:IMM_W-1] == {(W-IMM_W+1){signed_immediate_field[IMM_W-1]}})
    else $error("immediate not sign extended");

  a_cr_result: assert property (@(posedge clk) disable iff (rst)
    cr_valid && (cr_op == TCCR_CR_SET || cr_op == TCCR_CR_CLR)
    |=> cr_wr && cr_out[$past(cr_dst)] == ($past(cr_op) == TCCR_CR_SET))
    else $error("cr set or clear wrong");

  a_cr_not: assert property (@(posedge clk) disable iff (rst)
    cr_valid && cr_op == TCCR_CR_NOT |=> cr_out[$past(cr_dst)] == !$past(src_bit))
    else $error("cr invert wrong");

  a_trap_done: assert property (@(posedge clk) disable iff (rst)
    trap_valid |=> trap_done == ($past(hit) == COND_NONE))
    else $error("trap completion does not match masked conditions");

  a_trap_one: assert property (@(posedge clk) disable iff (rst)
    trap_valid |=> trap_req != trap_done)
    else $error("trap issue did not give exactly one outcome");

  a_trap_idle: assert property (@(posedge clk) disable iff (rst)
    !trap_valid |=> !trap_req && !trap_done)
    else $error("trap outcome without an issued trap");

  // Condition bits checked exclusive, then judged from the operands, not from the comparator
  a_sign_order: assert property (@(posedge clk) disable iff (rst)
    trap_valid |-> $onehot({cond[MSK_SLT], cond[MSK_SGT], cond[MSK_EQ]}))
    else $error("signed conditions not exclusive");

  a_unsign_order: assert property (@(posedge clk) disable iff (rst)
    trap_valid |-> $onehot({cond[MSK_ULT], cond[MSK_UGT], cond[MSK_EQ]}))
    else $error("unsigned conditions not exclusive");

  a_dword_eq: assert property (@(posedge clk) disable iff (rst)
    trap_valid && !trap_word |-> cond[MSK_EQ] == (first_operand_reg == b_sel))
    else $error("doubleword equal wrong");

  a_word_eq: assert property (@(posedge clk) disable iff (rst)
    trap_valid && trap_word |-> cond[MSK_EQ] ==
    (first_operand_reg[WORD_W-1:0] == b_sel[WORD_W-1:0]))
    else $error("word equal wrong");

  a_dword_ult: assert property (@(posedge clk) disable iff (rst)
    trap_valid && !trap_word |-> cond[MSK_ULT] == (first_operand_reg < b_sel))
    else $error("doubleword unsigned less-than wrong");

  a_word_ult: assert property (@(posedge clk) disable iff (rst)
    trap_valid && trap_word |-> cond[MSK_ULT] ==
    (first_operand_reg[WORD_W-1:0] < b_sel[WORD_W-1:0]))
    else $error("word unsigned less-than wrong");

  a_dword_slt: assert property (@(posedge clk) disable iff (rst)
    trap_valid && !trap_word |-> cond[MSK_SLT] ==
    ($signed(first_operand_reg) < $signed(b_sel)))
    else $error("doubleword signed less-than wrong");

  a_word_slt: assert property (@(posedge clk) disable iff (rst)
    trap_valid && trap_word |-> cond[MSK_SLT] ==
    ($signed(first_operand_reg[WORD_W-1:0]) < $signed(b_sel[WORD_W-1:0])))
    else $error("word signed less-than wrong");

  a_reg_sel: assert property (@(posedge clk) disable iff (rst)
    !trap_use_imm |-> b_sel == second_operand_reg)
    else $error("register operand not selected");

  a_imm_low: assert property (@(posedge clk) disable iff (rst)
    trap_use_imm |-> b_sel[IMM_W-1:0] == signed_immediate_field)
    else $error("immediate low bits lost");

  a_cr_move: assert property (@(posedge clk) disable iff (rst)
    cr_valid && cr_op == TCCR_CR_MOVE |=> cr_out[$past(cr_dst)] == $past(cr_in[cr_src]))
    else $error("cr copy wrong");

  // Only the addressed bit may differ from the incoming register
  a_cr_others: assert property (@(posedge clk) disable iff (rst)
    cr_valid |=> ((cr_out ^ $past(cr_in)) &
    ~({{(CR_W-1){1'b0}}, 1'b1} << $past(cr_dst))) == {CR_W{1'b0}})
    else $error("cr op disturbed other bits");

  a_cr_pulse: assert property (@(posedge clk) disable iff (rst)
    cr_valid |=> cr_wr)
    else $error("cr write strobe missing");

  a_cr_hold: assert property (@(posedge clk) disable iff (rst)
    !cr_valid |=> !cr_wr && $stable(cr_out))
    else $error("cr result changed without an op");
endmodule
`default_nettype wire
